/* core/pdn_pkg.sv */
`default_nettype none
package pdn_pkg;

	// ==========================================
	// control-space map
	localparam int        CS_ADDR_W      = 4;
	localparam logic [3:0] CS_STATUS     = 4'h0;
	localparam logic [3:0] CS_FRESET     = 4'h1;
	localparam logic [3:0] CS_CTRL       = 4'h2;
	localparam int        STATUS_EN_BIT  = 1;
	localparam logic [7:0] RESET_SIG     = 8'h59;
	localparam logic [7:0] RESET_RELEASE = 8'h00;
	localparam logic [2:0] GUARD_RST     = 3'h0;
	localparam logic [2:0] GUARD_NONE    = 3'h7;
	localparam logic [7:0] GUARD_MAX     = 8'h80;
	localparam int        KEY_BYTES      = 8;

	// ==========================================
	// controller register selects and fields
	localparam logic [2:0] NR_CMD        = 3'h0;
	localparam logic [2:0] NR_CONTROLLER_CONTROL_A      = 3'h1;
	localparam logic [2:0] NR_CTRLB      = 3'h2;
	localparam logic [2:0] NR_ADDR       = 3'h3;
	localparam logic [2:0] NR_DATA       = 3'h4;
	localparam int        COMMAND_EXECUTE_BIT_BIT      = 0;
	localparam int        TRIG_HI        = 7;
	localparam int        TRIG_LO        = 6;
	localparam logic [7:0] CMD_CRC_FLASH = 8'h78;
	localparam logic [7:0] CMD_CRC_SECT  = 8'h79;
	localparam int        ADDR_W         = 24;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		TRIG_NONE   = 2'h0,
		TRIG_ACTION = 2'h1,
		TRIG_READ   = 2'h2,
		TRIG_WRITE  = 2'h3
	} pdn_trig_type;

	typedef enum logic [2:0] {
		SP_APP    = 3'h0,
		SP_APPTBL = 3'h1,
		SP_BOOT   = 3'h2,
		SP_CAL    = 3'h3,
		SP_OTHER  = 3'h4
	} pdn_space_type;

endpackage
`default_nettype wire

/* core/pdn_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module pdn_guard
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// turnaround control
	input  wire logic [2:0] i_sel,
	input  wire logic       i_rx_to_tx,
	input  wire logic       i_tx_to_rx,
	input  wire logic       i_bit_tick,
	// status
	output logic            o_guard_active,
	output logic            o_guard_done
);
	import pdn_pkg::*;

	logic [7:0] cnt_r;
	logic [7:0] load_val;

	// ==========================================
	// idle bit count per select
	assign load_val = (i_sel == GUARD_NONE) ? 8'h00 : (GUARD_MAX >> i_sel);

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cnt_r          <= 8'h00;
			o_guard_active <= 1'b0;
			o_guard_done   <= 1'b0;
		end
		else if (i_rx_to_tx)
		begin
			cnt_r          <= load_val;
			o_guard_active <= (load_val != 8'h00);
			o_guard_done   <= (load_val == 8'h00);
		end
		else if (o_guard_active && i_bit_tick)
		begin
			cnt_r          <= cnt_r - 8'h01;
			o_guard_active <= (cnt_r != 8'h01);
			o_guard_done   <= (cnt_r == 8'h01);
		end
		else
			o_guard_done   <= 1'b0; // tx to rx inserts nothing
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	chk_guard_load_count: assert property (i_rx_to_tx && i_sel == 3'h0 |=> cnt_r == 8'h80)
		else $error("guard count not 128 for select 000");
	chk_guard_tx_rx: assert property (i_tx_to_rx && !i_rx_to_tx && !o_guard_active
		|=> !o_guard_active)
		else $error("guard inserted on tx to rx");
endmodule // pdn_guard
`default_nettype wire

/* core/pdn_nvm_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module pdn_nvm_gate
(
	// access request
	input  wire logic                   i_req,
	input  wire logic                   i_we,
	input  wire pdn_pkg::pdn_space_type i_space,
	input  wire logic                   i_from_ext,
	// state
	input  wire logic                   i_if_en,
	input  wire logic [2:0]             i_ext_lock,
	input  wire logic [2:0]             i_self_lock,
	input  wire logic                   i_programming,
	// decision
	output logic                        o_grant
);
	import pdn_pkg::*;

	logic lock_hit;
	logic deny;

	// ==========================================
	// lock, calibration and programming blocks
	always_comb
	begin
		lock_hit = 1'b0;
		if (i_space == SP_APP || i_space == SP_APPTBL || i_space == SP_BOOT)
			lock_hit = i_from_ext ? i_ext_lock[i_space[1:0]] : i_self_lock[i_space[1:0]];
	end

	assign deny = lock_hit
		| (i_from_ext & ~i_if_en)
		| (i_from_ext & i_we & (i_space == SP_CAL))
		| (i_programming & (i_we | i_from_ext | (i_space == SP_APP)));

	assign o_grant = i_req & ~deny;
endmodule // pdn_nvm_gate
`default_nettype wire

/* core/pdn_link_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pdn_link_top
#(
	parameter logic [63:0] KEY_VALUE = 64'h0123_4567_89AB_CDEF // arbitrary value
)
(
	// clock and reset
	input  wire logic                           i_clk,
	input  wire logic                           i_reset_n,
	// control-space access from the instruction decoder
	input  wire logic                           i_cs_load,
	input  wire logic                           i_cs_store,
	input  wire logic [pdn_pkg::CS_ADDR_W-1:0]  i_cs_addr,
	input  wire logic [7:0]                     i_cs_wdata,
	output logic [7:0]                          o_cs_rdata,
	output logic                                o_cs_rvalid,
	// key bytes
	input  wire logic                           i_key_start,
	input  wire logic                           i_key_valid,
	input  wire logic [7:0]                     i_key_byte,
	// link turnaround
	input  wire logic                           i_rx_to_tx,
	input  wire logic                           i_tx_to_rx,
	input  wire logic                           i_bit_tick,
	output logic                                o_guard_active,
	output logic                                o_guard_done,
	// device state
	output logic                                o_forced_reset,
	output logic                                o_if_enabled,
	// controller register writes, link side
	input  wire logic                           i_ext_reg_wr,
	input  wire logic [2:0]                     i_ext_reg_sel,
	input  wire logic [pdn_pkg::ADDR_W-1:0]     i_ext_reg_wdata,
	// controller register writes, software side
	input  wire logic                           i_sw_reg_wr,
	input  wire logic [2:0]                     i_sw_reg_sel,
	input  wire logic [pdn_pkg::ADDR_W-1:0]     i_sw_reg_wdata,
	input  wire logic                           i_ccp_open,
	// memory accesses
	input  wire logic                           i_ext_mem_req,
	input  wire logic                           i_ext_mem_we,
	input  wire pdn_pkg::pdn_space_type         i_ext_mem_space,
	input  wire logic                           i_sw_mem_req,
	input  wire logic                           i_sw_mem_we,
	input  wire pdn_pkg::pdn_space_type         i_sw_mem_space,
	output logic                                o_ext_mem_ack,
	output logic                                o_ext_mem_nak,
	output logic                                o_sw_mem_ack,
	output logic                                o_sw_mem_nak,
	// lock controls
	input  wire logic [2:0]                     i_ext_lock,
	input  wire logic [2:0]                     i_self_lock,
	// operation engine
	input  wire logic                           i_op_done,
	output logic                                o_op_start,
	output logic [7:0]                          o_op_cmd,
	output logic [pdn_pkg::ADDR_W-1:0]          o_op_addr,
	output logic [7:0]                          o_op_data,
	output logic [7:0]                          o_op_ctrlb,
	output logic                                o_busy,
	output logic                                o_programming
);
	import pdn_pkg::*;

	typedef enum logic [0:0] {
		NV_IDLE,
		NV_BUSY
	} pdn_nv_state_type;

	// ==========================================
	// declarations
	logic                   nonvolatile_if_enabled_r;
	logic                   freset_r;
	logic [2:0]             guard_sel_r;
	logic [55:0]            key_sr_r;
	logic [3:0]             key_cnt_r;
	logic                   key_hit;
	logic                   st_status;
	logic                   st_freset;
	logic                   st_ctrl;
	logic [7:0]             cs_rd_nxt;
	pdn_nv_state_type       nv_state_r;
	pdn_trig_type           cmd_trig;
	pdn_trig_type           op_trig_r;
	logic [7:0]             cmd_r;
	logic [7:0]             ctrlb_r;
	logic [ADDR_W-1:0]      addr_r;
	logic [7:0]             data_r;
	logic                   ext_wr_ok;
	logic                   reg_wr;
	logic                   reg_take;
	logic [2:0]             reg_sel;
	logic [ADDR_W-1:0]      reg_wdata;
	logic                   reg_trusted;
	logic                   command_execute_bit_wr;
	logic                   use_ext;
	logic                   mem_req;
	logic                   mem_we;
	pdn_space_type          mem_space;
	logic                   mem_grant;
	logic                   mem_trig;
	logic                   op_start;

	// ==========================================
	// control-space strobes
	assign st_status = i_cs_store && (i_cs_addr == CS_STATUS);
	assign st_freset = i_cs_store && (i_cs_addr == CS_FRESET);
	assign st_ctrl   = i_cs_store && (i_cs_addr == CS_CTRL);

	// ==========================================
	// key reception
	assign key_hit = i_key_valid && (key_cnt_r == 4'(KEY_BYTES - 1))
		&& ({key_sr_r, i_key_byte} == KEY_VALUE);

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			key_sr_r  <= 56'h0;
			key_cnt_r <= 4'h0;
		end
		else if (i_key_start)
			key_cnt_r <= 4'h0;
		else if (i_key_valid)
		begin
			key_sr_r  <= {key_sr_r[47:0], i_key_byte};
			key_cnt_r <= (key_cnt_r == 4'(KEY_BYTES - 1)) ? 4'h0 : key_cnt_r + 4'h1;
		end
	end

	// ==========================================
	// interface enable status
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			nonvolatile_if_enabled_r <= 1'b0;
		else if (key_hit)
			nonvolatile_if_enabled_r <= 1'b1;
		else if (st_status)
			nonvolatile_if_enabled_r <= 1'b0;
	end

	assign o_if_enabled = nonvolatile_if_enabled_r;

	// ==========================================
	// forced reset
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			freset_r <= 1'b0;
		else if (st_freset)
			freset_r <= (i_cs_wdata == RESET_SIG);
	end

	assign o_forced_reset = freset_r;

	// ==========================================
	// guard select
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			guard_sel_r <= GUARD_RST;
		else if (st_ctrl)
			guard_sel_r <= i_cs_wdata[2:0];
	end

	pdn_guard u_guard
	(
		.i_clk          (i_clk),
		.i_reset_n      (i_reset_n),
		.i_sel          (guard_sel_r),
		.i_rx_to_tx     (i_rx_to_tx),
		.i_tx_to_rx     (i_tx_to_rx),
		.i_bit_tick     (i_bit_tick),
		.o_guard_active (o_guard_active),
		.o_guard_done   (o_guard_done)
	);

	// ==========================================
	// control-space read
	always_comb
	begin
		cs_rd_nxt = 8'h00;
		unique case (i_cs_addr)
			CS_STATUS: cs_rd_nxt[STATUS_EN_BIT] = nonvolatile_if_enabled_r;
			CS_FRESET: cs_rd_nxt[0] = freset_r;
			CS_CTRL:   cs_rd_nxt[2:0] = guard_sel_r;
			default:   cs_rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_cs_rdata  <= 8'h00;
			o_cs_rvalid <= 1'b0;
		end
		else
		begin
			o_cs_rvalid <= i_cs_load;
			if (i_cs_load)
				o_cs_rdata <= cs_rd_nxt;
		end
	end

	// ==========================================
	// controller register writes
	assign ext_wr_ok   = i_ext_reg_wr && nonvolatile_if_enabled_r;
	assign reg_wr      = ext_wr_ok || i_sw_reg_wr;
	assign reg_sel     = ext_wr_ok ? i_ext_reg_sel : i_sw_reg_sel;
	assign reg_wdata   = ext_wr_ok ? i_ext_reg_wdata : i_sw_reg_wdata;
	assign reg_trusted = ext_wr_ok || i_ccp_open;
	assign reg_take    = reg_wr && (nv_state_r == NV_IDLE);
	assign command_execute_bit_wr    = reg_take && (reg_sel == NR_CONTROLLER_CONTROL_A)
		&& reg_wdata[COMMAND_EXECUTE_BIT_BIT] && reg_trusted;

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cmd_r   <= 8'h00;
			ctrlb_r <= 8'h00;
			addr_r  <= '0;
			data_r  <= 8'h00;
		end
		else if (reg_take)
		begin
			if (reg_sel == NR_CMD)
				cmd_r <= reg_wdata[7:0];
			if (reg_sel == NR_CTRLB)
				ctrlb_r <= reg_wdata[7:0];
			if (reg_sel == NR_ADDR)
				addr_r <= reg_wdata;
			if (reg_sel == NR_DATA)
				data_r <= reg_wdata[7:0];
		end
	end

	assign cmd_trig = pdn_trig_type'(cmd_r[TRIG_HI:TRIG_LO]);

	// ==========================================
	// memory access arbitration
	assign use_ext   = i_ext_mem_req;
	assign mem_req   = i_ext_mem_req || i_sw_mem_req;
	assign mem_we    = use_ext ? i_ext_mem_we : i_sw_mem_we;
	assign mem_space = use_ext ? i_ext_mem_space : i_sw_mem_space;

	pdn_nvm_gate u_gate
	(
		.i_req         (mem_req),
		.i_we          (mem_we),
		.i_space       (mem_space),
		.i_from_ext    (use_ext),
		.i_if_en       (nonvolatile_if_enabled_r),
		.i_ext_lock    (i_ext_lock),
		.i_self_lock   (i_self_lock),
		.i_programming (o_programming),
		.o_grant       (mem_grant)
	);

	assign o_ext_mem_ack = use_ext && mem_grant;
	assign o_ext_mem_nak = use_ext && !mem_grant;
	assign o_sw_mem_ack  = i_sw_mem_req && !use_ext && mem_grant;
	assign o_sw_mem_nak  = i_sw_mem_req && !(mem_grant && !use_ext);

	assign mem_trig = mem_grant && (nv_state_r == NV_IDLE) && (
		((cmd_trig == TRIG_READ) && !mem_we) ||
		((cmd_trig == TRIG_WRITE) && mem_we && (use_ext || i_ccp_open)));

	// crc commands are action type and run from the link side, or from software only while i_ccp_open is set
	assign op_start = (nv_state_r == NV_IDLE)
		&& ((command_execute_bit_wr && (cmd_trig == TRIG_ACTION)) || mem_trig);

	// ==========================================
	// operation state
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			nv_state_r <= NV_IDLE;
			op_trig_r  <= TRIG_NONE;
		end
		else
		begin
			unique case (nv_state_r)
				NV_IDLE:
					if (op_start)
					begin
						nv_state_r <= NV_BUSY;
						op_trig_r  <= cmd_trig;
					end
				NV_BUSY:
					if (i_op_done)
						nv_state_r <= NV_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_op_start <= 1'b0;
			o_op_cmd   <= 8'h00;
			o_op_addr  <= '0;
			o_op_data  <= 8'h00;
			o_op_ctrlb <= 8'h00;
		end
		else
		begin
			o_op_start <= op_start;
			if (op_start)
			begin
				o_op_cmd   <= cmd_r;
				o_op_addr  <= addr_r;
				o_op_data  <= data_r;
				o_op_ctrlb <= ctrlb_r;
			end
		end
	end

	assign o_busy        = (nv_state_r == NV_BUSY);
	assign o_programming = o_busy && (op_trig_r == TRIG_WRITE);

	// ==========================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	chk_status_reserved: assert property (i_cs_load && i_cs_addr == 4'h0
		|=> o_cs_rvalid && o_cs_rdata[7:2] == 6'h00 && !o_cs_rdata[0])
		else $error("status reserved bits not zero");
	chk_key_enable: assert property ($rose(nonvolatile_if_enabled_r) |-> $past(key_hit))
		else $error("interface enabled without key");
	chk_status_clear: assert property (st_status && !key_hit |=> !nonvolatile_if_enabled_r)
		else $error("status write did not disable");
	chk_reset_hold: assert property (st_freset && i_cs_wdata == 8'h59
		|=> o_forced_reset until_with (st_freset && i_cs_wdata != 8'h59))
		else $error("forced reset not held");
	chk_reset_read: assert property (i_cs_load && i_cs_addr == 4'h1 && !st_freset
		|=> o_cs_rdata == {7'h00, o_forced_reset})
		else $error("forced reset readback wrong");
	chk_busy_block: assert property (o_busy && reg_wr
		|=> $stable(cmd_r) && $stable(addr_r) && $stable(data_r))
		else $error("register written while busy");
	chk_busy_release: assert property (o_busy && i_op_done |=> !o_busy)
		else $error("busy not cleared on done");
	chk_cal_readonly: assert property (i_ext_mem_req && i_ext_mem_we
		&& i_ext_mem_space == SP_CAL |-> !o_ext_mem_ack)
		else $error("calibration row written externally");
	chk_prog_block: assert property (o_programming && i_ext_mem_req |-> o_ext_mem_nak)
		else $error("external access during programming");
	chk_action_start: assert property (command_execute_bit_wr && cmd_trig == TRIG_ACTION && !o_busy
		|=> o_op_start ##1 o_busy)
		else $error("action command did not start");
endmodule // pdn_link_top
`default_nettype wire

/* tb/pdn_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pdn_engine_model
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// engine handshake
	input  wire logic       i_start,
	input  wire logic [7:0] i_delay,
	output logic            o_done
);
	// ==========================================
	// completion after a chosen number of cycles
	logic [7:0] cnt_r;
	logic       run_r;

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cnt_r  <= 8'h00;
			run_r  <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start)
			begin
				run_r <= 1'b1;
				cnt_r <= i_delay;
			end
			else if (run_r)
			begin
				if (cnt_r == 8'h00)
				begin
					run_r  <= 1'b0;
					o_done <= 1'b1;
				end
				else
					cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule // pdn_engine_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pdn_pkg::*;
	// ==========================================
	// signals
	localparam logic [63:0] KEY = 64'h1122_3344_5566_7788; // arbitrary value
	logic          clk, rst_n, cs_load, cs_store, cs_rvalid, key_start, key_valid;
	logic          rx_to_tx, tx_to_rx, bit_tick, guard_active, guard_done;
	logic          forced_reset, if_enabled, ext_reg_wr, sw_reg_wr, ccp_open;
	logic          ext_mem_req, ext_mem_we, sw_mem_req, sw_mem_we, ext_ack, ext_nak;
	logic          sw_ack, sw_nak, op_done, op_start, busy, programming, a, n, st;
	logic [3:0]    cs_addr;
	logic [7:0]    cs_wdata, cs_rdata, key_byte, op_cmd, delay;
	logic [2:0]    ext_reg_sel, sw_reg_sel, ext_lock, self_lock;
	logic [23:0]   ext_reg_wdata, sw_reg_wdata;
	pdn_space_type ext_mem_space, sw_mem_space;
	int            miscompares = 0;
	int            num_checks = 0;

	pdn_link_top #(.KEY_VALUE(KEY)) u_pdn_link_top (.i_clk(clk), .i_reset_n(rst_n),
		.i_cs_load(cs_load), .i_cs_store(cs_store), .i_cs_addr(cs_addr),
		.i_cs_wdata(cs_wdata), .o_cs_rdata(cs_rdata), .o_cs_rvalid(cs_rvalid),
		.i_key_start(key_start), .i_key_valid(key_valid), .i_key_byte(key_byte),
		.i_rx_to_tx(rx_to_tx), .i_tx_to_rx(tx_to_rx), .i_bit_tick(bit_tick),
		.o_guard_active(guard_active), .o_guard_done(guard_done),
		.o_forced_reset(forced_reset), .o_if_enabled(if_enabled),
		.i_ext_reg_wr(ext_reg_wr), .i_ext_reg_sel(ext_reg_sel),
		.i_ext_reg_wdata(ext_reg_wdata), .i_sw_reg_wr(sw_reg_wr),
		.i_sw_reg_sel(sw_reg_sel), .i_sw_reg_wdata(sw_reg_wdata), .i_ccp_open(ccp_open),
		.i_ext_mem_req(ext_mem_req), .i_ext_mem_we(ext_mem_we),
		.i_ext_mem_space(ext_mem_space), .i_sw_mem_req(sw_mem_req),
		.i_sw_mem_we(sw_mem_we), .i_sw_mem_space(sw_mem_space), .o_ext_mem_ack(ext_ack),
		.o_ext_mem_nak(ext_nak), .o_sw_mem_ack(sw_ack), .o_sw_mem_nak(sw_nak),
		.i_ext_lock(ext_lock), .i_self_lock(self_lock), .i_op_done(op_done),
		.o_op_start(op_start), .o_op_cmd(op_cmd), .o_op_addr(), .o_op_data(),
		.o_op_ctrlb(), .o_busy(busy), .o_programming(programming));

	pdn_engine_model u_pdn_engine_model (.i_clk(clk), .i_reset_n(rst_n),
		.i_start(op_start), .i_delay(delay), .o_done(op_done));

	// ==========================================
	// helpers
	task automatic results;
		$display("checks=%0d miscompares=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tmo;
		miscompares++;
		$display("BAD t=%0t wait expired got=%h exp=%h", $time, 0, 1);
		results();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cs_st(input logic [3:0] ad, input logic [7:0] d);
		@(posedge clk);
		cs_store <= 1'b1;
		cs_addr  <= ad;
		cs_wdata <= d;
		@(posedge clk);
		cs_store <= 1'b0;
		#1;
	endtask

	task automatic cs_ld(input logic [3:0] ad, input logic [7:0] exp);
		int k = 0;
		@(posedge clk);
		cs_load <= 1'b1;
		cs_addr <= ad;
		@(posedge clk);
		cs_load <= 1'b0;
		#1;
		while (cs_rvalid !== 1'b1 && k < 4)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == 4)
			tmo();
		chk(cs_rdata, exp);
	endtask

	task automatic key(input logic [63:0] kv);
		@(posedge clk);
		key_start <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			key_start <= 1'b0;
			key_valid <= 1'b1;
			key_byte  <= kv[63-8*i -: 8];
		end
		@(posedge clk);
		key_valid <= 1'b0;
		#1;
	endtask

	task automatic reg_wr(input logic x, input logic [2:0] s, input logic [23:0] d);
		@(posedge clk);
		ext_reg_wr    <= x;
		sw_reg_wr     <= ~x;
		ext_reg_sel   <= s;
		sw_reg_sel    <= s;
		ext_reg_wdata <= d;
		sw_reg_wdata  <= d;
		@(posedge clk);
		ext_reg_wr <= 1'b0;
		sw_reg_wr  <= 1'b0;
		#1;
		st = op_start;
	endtask

	task automatic mem(input logic x, input logic w, input pdn_space_type sp);
		@(posedge clk);
		ext_mem_req   <= x;
		sw_mem_req    <= ~x;
		ext_mem_we    <= w;
		sw_mem_we     <= w;
		ext_mem_space <= sp;
		sw_mem_space  <= sp;
		#1;
		a = x ? ext_ack : sw_ack;
		n = x ? ext_nak : sw_nak;
		@(posedge clk);
		ext_mem_req <= 1'b0;
		sw_mem_req  <= 1'b0;
		#1;
		st = op_start;
	endtask

	task automatic wait_done;
		int k = 0;
		while (k < 60)
		begin
			@(posedge clk);
			#1;
			if (op_done === 1'b1)
				break;
			k++;
		end
		if (k == 60)
			tmo();
		@(posedge clk);
		#1;
		chk(busy, 1'b0);
	endtask

	task automatic guard(input logic [2:0] s);
		int k = 0;
		@(posedge clk);
		rx_to_tx <= 1'b1;
		while (k < 200)
		begin
			@(posedge clk);
			rx_to_tx <= 1'b0;
			bit_tick <= 1'b1;
			k++;
			#1;
			if (guard_done === 1'b1)
				break;
		end
		if (k == 200)
			tmo();
		@(posedge clk);
		bit_tick <= 1'b0;
		chk(k, (s == GUARD_NONE) ? 1 : (128 >> s) + 1);
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs;
		cs_ld(CS_STATUS, 8'h00);
		cs_ld(CS_FRESET, 8'h00);
		cs_ld(CS_CTRL, {5'h00, GUARD_RST});
		cs_st(4'h5, 8'hFF);
		cs_ld(4'h5, 8'h00);
		cs_st(CS_FRESET, RESET_SIG);
		chk(forced_reset, 1'b1);
		cs_ld(CS_FRESET, 8'h01);
		cs_st(CS_FRESET, 8'h58);
		chk(forced_reset, 1'b0);
		cs_st(CS_FRESET, RESET_SIG);
		cs_st(CS_FRESET, RESET_RELEASE);
		chk(forced_reset, 1'b0);
		$display("test regs done");
	endtask

	task automatic t_key;
		key(KEY ^ 64'h1);
		chk(if_enabled, 1'b0);
		key(KEY);
		chk(if_enabled, 1'b1);
		cs_ld(CS_STATUS, 8'h02);
		cs_st(CS_STATUS, 8'h00);
		chk(if_enabled, 1'b0);
		key(KEY);
		chk(if_enabled, 1'b1);
		$display("test key done");
	endtask

	task automatic t_guard;
		guard(GUARD_RST);
		for (int s = 7; s >= 0; s--)
		begin
			cs_st(CS_CTRL, {5'h00, 3'(s)});
			cs_ld(CS_CTRL, {5'h00, 3'(s)});
			guard(3'(s));
		end
		@(posedge clk);
		tx_to_rx <= 1'b1;
		bit_tick <= 1'b1;
		repeat (3)
		begin
			@(posedge clk);
			tx_to_rx <= 1'b0;
			#1;
			chk({guard_active, guard_done}, 2'b00);
		end
		@(posedge clk);
		bit_tick <= 1'b0;
		$display("test guard done");
	endtask

	task automatic t_ctrl;
		ccp_open <= 1'b1;
		reg_wr(1'b0, NR_CMD, {16'h0, CMD_CRC_FLASH});
		reg_wr(1'b0, NR_CONTROLLER_CONTROL_A, 24'h1);
		chk(st, 1'b1);
		chk(op_cmd, CMD_CRC_FLASH);
		chk(busy, 1'b1);
		reg_wr(1'b0, NR_CMD, 24'h11);
		wait_done();
		reg_wr(1'b0, NR_CONTROLLER_CONTROL_A, 24'h1);
		chk(op_cmd, CMD_CRC_FLASH);
		wait_done();
		ccp_open <= 1'b0;
		reg_wr(1'b0, NR_CONTROLLER_CONTROL_A, 24'h1);
		chk({st, busy}, 2'b00);
		reg_wr(1'b1, NR_CMD, {16'h0, CMD_CRC_SECT});
		reg_wr(1'b1, NR_CONTROLLER_CONTROL_A, 24'h1);
		chk({st, op_cmd}, {1'b1, CMD_CRC_SECT});
		wait_done();
		$display("test ctrl done");
	endtask

	task automatic t_mem;
		ccp_open <= 1'b1;
		reg_wr(1'b0, NR_CMD, 24'h80);
		mem(1'b0, 1'b0, SP_APP);
		chk({a, st}, 2'b11);
		wait_done();
		delay <= 8'h14;
		reg_wr(1'b1, NR_CMD, 24'hC0);
		mem(1'b1, 1'b1, SP_APP);
		chk({st, programming}, 2'b11);
		mem(1'b1, 1'b0, SP_BOOT);
		chk(n, 1'b1);
		mem(1'b0, 1'b0, SP_APP);
		chk(n, 1'b1);
		mem(1'b0, 1'b1, SP_OTHER);
		chk(n, 1'b1);
		wait_done();
		mem(1'b1, 1'b1, SP_CAL);
		chk({a, n}, 2'b01);
		mem(1'b1, 1'b0, SP_CAL);
		chk({a, n}, 2'b10);
		ext_lock <= 3'h1;
		mem(1'b1, 1'b0, SP_APP);
		chk(n, 1'b1);
		mem(1'b0, 1'b0, SP_APP);
		chk(a, 1'b1);
		ext_lock  <= 3'h0;
		self_lock <= 3'h1;
		mem(1'b0, 1'b0, SP_APP);
		chk(n, 1'b1);
		$display("test mem done");
	endtask

	// ==========================================
	// clock, watchdog and main sequence
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (50000) @(posedge clk);
		tmo();
	end

	initial
	begin
		{rst_n, cs_load, cs_store, key_start, key_valid, rx_to_tx, tx_to_rx} = '0;
		{bit_tick, ext_reg_wr, sw_reg_wr, ccp_open, ext_mem_req, ext_mem_we} = '0;
		{sw_mem_req, sw_mem_we, cs_addr, cs_wdata, key_byte, ext_lock, self_lock} = '0;
		{ext_reg_sel, sw_reg_sel, ext_reg_wdata, sw_reg_wdata} = '0;
		ext_mem_space = SP_APP;
		sw_mem_space  = SP_APP;
		delay         = 8'h03;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_key();
		t_guard();
		t_ctrl();
		t_mem();
		results();
	end
endmodule // testbench
`default_nettype wire
